/* design/dpbr_pkg.sv */
package dpbr_pkg;
  // array and lane geometry
  localparam int DW    = 32;   // widest data-lane view
  localparam int PW    = 4;    // widest parity-lane view
  localparam int TW    = 36;   // one stored word, parity above data
  localparam int AW    = 14;   // widest location select (one-bit view)
  localparam int WORDS = 512;  // stored words of TW bits
  localparam int WIDX  = 9;    // index width of a stored word
  localparam int PAW   = 12;   // apb address bits decoded

  // apb register byte addresses
  localparam logic [PAW-1:0] ADDR_CTRL       = 12'h000;
  localparam logic [PAW-1:0] ADDR_PRESET_A   = 12'h004;
  localparam logic [PAW-1:0] ADDR_PRESET_B   = 12'h008;
  localparam logic [PAW-1:0] ADDR_PRESET_PAR = 12'h00C;
  localparam logic [PAW-1:0] ADDR_STATUS     = 12'h010;

  // control register field positions
  localparam int CTRL_WA_LSB     = 0;   // port a width code, 3 bits
  localparam int CTRL_MA_LSB     = 6;   // port a write mode, 2 bits
  localparam int CTRL_SINGLE_BIT = 10;  // one-port instance
  localparam int CTRL_INVA_LSB   = 11;  // port a inversions, 4 bits
  localparam int CTRL_W_STEP     = 3;   // port b fields follow port a
  localparam int CTRL_M_STEP     = 2;
  localparam int CTRL_INV_STEP   = 4;
  localparam int INV_CLK         = 0;
  localparam int INV_GATE        = 1;
  localparam int INV_WRITE       = 2;
  localparam int INV_PRESET      = 3;

  // reset values: both ports 36 bits wide, write-first, dual port
  localparam logic [31:0] CTRL_RST   = 32'h0000_002D;
  localparam logic [31:0] PRESET_RST = 32'h0000_0000;
  localparam logic [TW-1:0] MEM_INIT_RST = 36'h0_0000_0000;

  // width codes: 0..5 give 1,2,4,9,18,36 total bits
  localparam logic [2:0] WSEL_MAX     = 3'h5;
  localparam logic [2:0] WSEL_PAR_MIN = 3'h3;

  // write behaviour of a port
  typedef enum logic [1:0] {
    WM_WRITE_FIRST = 2'b00,
    WM_READ_FIRST  = 2'b01,
    WM_NO_CHANGE   = 2'b10
  } dpbr_wmode_t;
endpackage

/* design/dpbr_top.sv */
`timescale 1ns/1ps
// What this block does
// - array holds 18432 bits, 16384 data
// - two identical ports, each own controls
// - both ports read and write shared array
// - each port width 1,2,4,9,18,36 independently
// - total width is data plus parity lanes
// - no parity lanes at widths 4,2,1
// - select lines are fourteen minus log2 width
// - depth is two to select lines
// - mixed widths address the same bits
// - narrow writes read back as wide word
// - wide write reads back as slices
// - parity bits follow their data byte
// - upper input bits shared with multiplier
// - dual port or port-a-only instance
// - init contents, preset, widths, write mode configurable
// - store only with gate and write asserted
// - read shows selected location on edge
// - write mode picks new, old or hold
// - controls active high, each optionally inverted
module dpbr_top #(
  parameter logic [dpbr_pkg::TW-1:0] MEM_INIT = dpbr_pkg::MEM_INIT_RST  // fill value of every word
) (
  input  wire logic                     I_CORE_CLK,
  input  wire logic                     I_SYS_RST,
  // apb slave
  input  wire logic                     I_PSEL,
  input  wire logic                     I_PENABLE,
  input  wire logic                     I_PWRITE,
  input  wire logic [dpbr_pkg::PAW-1:0] I_PADDR,
  input  wire logic [31:0]              I_PWDATA,
  output logic      [31:0]              O_PRDATA,
  output logic                          O_PREADY,
  output logic                          O_PSLVERR,
  // port a
  input  wire logic                     I_PA_CLK,
  input  wire logic                     I_PA_GATE,
  input  wire logic                     I_PA_WRITE,
  input  wire logic                     I_PA_OUTPUT_PRESET,
  input  wire logic [dpbr_pkg::AW-1:0]  I_PA_ADDR,
  input  wire logic [dpbr_pkg::DW-1:0]  I_PA_DATA_IN_LANES,
  input  wire logic [dpbr_pkg::PW-1:0]  I_PA_PARITY_IN_LANES,
  output logic      [dpbr_pkg::DW-1:0]  O_PA_DATA_OUT_LANES,
  output logic      [dpbr_pkg::PW-1:0]  O_PA_PARITY_OUT_LANES,
  output logic      [15:0]              O_MULT_A_HI,
  // port b
  input  wire logic                     I_PB_CLK,
  input  wire logic                     I_PB_GATE,
  input  wire logic                     I_PB_WRITE,
  input  wire logic                     I_PB_OUTPUT_PRESET,
  input  wire logic [dpbr_pkg::AW-1:0]  I_PB_ADDR,
  input  wire logic [dpbr_pkg::DW-1:0]  I_PB_DATA_IN_LANES,
  input  wire logic [dpbr_pkg::PW-1:0]  I_PB_PARITY_IN_LANES,
  output logic      [dpbr_pkg::DW-1:0]  O_PB_DATA_OUT_LANES,
  output logic      [dpbr_pkg::PW-1:0]  O_PB_PARITY_OUT_LANES,
  output logic      [15:0]              O_MULT_B_HI
);
  import dpbr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers and apb decode
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]   ctrl_r;        // widths, modes, single-port, inversions
  logic [31:0]   preset_r [2];  // output preset data per port
  logic [31:0]   ppar_r;        // output preset parity, a in [3:0], b in [7:4]
  logic [31:0]   prdata_r;      // read data captured in the setup phase
  logic [15:0]   wcnt_r   [2];  // completed writes per port
  logic [31:0]   rd_mux;        // register read selection
  wire           apb_setup = I_PSEL & ~I_PENABLE;
  wire           apb_acc   = I_PSEL & I_PENABLE;
  wire           hit_ctrl  = (I_PADDR == ADDR_CTRL);
  wire           hit_pra   = (I_PADDR == ADDR_PRESET_A);
  wire           hit_prb   = (I_PADDR == ADDR_PRESET_B);
  wire           hit_ppar  = (I_PADDR == ADDR_PRESET_PAR);
  wire           hit_stat  = (I_PADDR == ADDR_STATUS);
  wire           mapped    = hit_ctrl | hit_pra | hit_prb | hit_ppar | hit_stat;
  wire           apb_wr    = apb_acc & I_PWRITE & mapped;
  wire           single    = ctrl_r[CTRL_SINGLE_BIT];  // port b is absent

  // zero wait states: every access completes in its first access cycle
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = apb_acc & ~mapped;
  assign O_PRDATA  = prdata_r;

  // read selection, unmapped reads return zero
  assign rd_mux = hit_ctrl ? ctrl_r      :
                  hit_pra  ? preset_r[0] :
                  hit_prb  ? preset_r[1] :
                  hit_ppar ? ppar_r      :
                  hit_stat ? {wcnt_r[1], wcnt_r[0]} : 32'h0000_0000;

  // register writes land at the access edge, status is read-only
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ctrl_r      <= CTRL_RST;
      preset_r[0] <= PRESET_RST;
      preset_r[1] <= PRESET_RST;
      ppar_r      <= PRESET_RST;
      prdata_r    <= 32'h0000_0000;
    end else begin
      if (apb_setup && !I_PWRITE) begin
        prdata_r <= rd_mux;
      end
      if (apb_wr && hit_ctrl) begin
        ctrl_r <= I_PWDATA;
      end
      if (apb_wr && hit_pra) begin
        preset_r[0] <= I_PWDATA;
      end
      if (apb_wr && hit_prb) begin
        preset_r[1] <= I_PWDATA;
      end
      if (apb_wr && hit_ppar) begin
        ppar_r <= I_PWDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port lanes gathered per port index, 0 is a and 1 is b
  ////////////////////////////////////////////////////////////////////////////
  logic [TW-1:0] mem_q   [WORDS];  // 512 x 36 storage
  logic          clk_in  [2];      // raw port clock sample
  logic          gate_in [2];
  logic          wr_in   [2];
  logic          pre_in  [2];
  logic [AW-1:0] addr_in [2];
  logic [DW-1:0] din     [2];
  logic [PW-1:0] pin     [2];
  logic [DW-1:0] dout_r  [2];      // output data lanes
  logic [PW-1:0] pout_r  [2];      // output parity lanes
  logic          clkp_r  [2];      // port clock one core cycle ago
  logic          go      [2];      // active edge with gate asserted
  logic          wr      [2];      // go with write strobe asserted
  logic          pre_act [2];
  logic          we_act  [2];
  logic [2:0]    k       [2];      // log2 of data-lane width
  logic [1:0]    wmode   [2];
  logic [WIDX-1:0] word  [2];      // stored word touched
  logic [TW-1:0] msk     [2];      // bits of that word owned by the port
  logic [TW-1:0] wd      [2];      // write data aligned into the word
  logic [DW-1:0] dlow    [2];      // data-lane width mask
  logic [PW-1:0] plow    [2];      // parity-lane width mask
  logic [DW-1:0] rd_d    [2];      // read data at the selected location
  logic [PW-1:0] rd_p    [2];

  assign clk_in[0]  = I_PA_CLK;
  assign clk_in[1]  = I_PB_CLK;
  assign gate_in[0] = I_PA_GATE;
  assign gate_in[1] = I_PB_GATE;
  assign wr_in[0]   = I_PA_WRITE;
  assign wr_in[1]   = I_PB_WRITE;
  assign pre_in[0]  = I_PA_OUTPUT_PRESET;
  assign pre_in[1]  = I_PB_OUTPUT_PRESET;
  assign addr_in[0] = I_PA_ADDR;
  assign addr_in[1] = I_PB_ADDR;
  assign din[0]     = I_PA_DATA_IN_LANES;
  assign din[1]     = I_PB_DATA_IN_LANES;
  assign pin[0]     = I_PA_PARITY_IN_LANES;
  assign pin[1]     = I_PB_PARITY_IN_LANES;

  assign O_PA_DATA_OUT_LANES   = dout_r[0];
  assign O_PA_PARITY_OUT_LANES = pout_r[0];
  assign O_PB_DATA_OUT_LANES   = dout_r[1];
  assign O_PB_PARITY_OUT_LANES = pout_r[1];

  // upper input bits double as multiplier operand bits
  assign O_MULT_A_HI = I_PA_DATA_IN_LANES[31:16];
  assign O_MULT_B_HI = I_PB_DATA_IN_LANES[31:16];

  ////////////////////////////////////////////////////////////////////////////
  // per-port control decode, address mapping and output registers
  ////////////////////////////////////////////////////////////////////////////
  for (genvar p = 0; p < 2; p++) begin : g_port
    wire [2:0] raw   = ctrl_r[CTRL_WA_LSB + CTRL_W_STEP*p +: 3];
    wire [3:0] inv   = ctrl_r[CTRL_INVA_LSB + CTRL_INV_STEP*p +: 4];
    wire       en_p  = (p == 0) ? 1'b1 : ~single;
    // port clock is sampled; the active edge is rising, or falling if inverted
    wire       edge_p = (clk_in[p] ^ inv[INV_CLK]) & ~(clkp_r[p] ^ inv[INV_CLK]);
    // illegal codes fall back to the widest view rather than aliasing
    assign k[p]       = (raw > WSEL_MAX) ? WSEL_MAX : raw;
    assign wmode[p]   = ctrl_r[CTRL_MA_LSB + CTRL_M_STEP*p +: 2];
    assign we_act[p]  = wr_in[p] ^ inv[INV_WRITE];
    assign pre_act[p] = pre_in[p] ^ inv[INV_PRESET];
    assign go[p]      = edge_p & (gate_in[p] ^ inv[INV_GATE]) & en_p;
    assign wr[p]      = go[p] & we_act[p];

    // location select uses 14-k lines, so the bit offset spans all 14 bits
    wire [AW-1:0] bitpos = AW'(addr_in[p] << k[p]);
    wire [4:0]    off    = bitpos[4:0];
    wire [1:0]    lane   = bitpos[4:3];  // byte of the word, picks the parity bit
    wire [5:0]    dw     = 6'h01 << k[p];
    // parity lanes only exist from the 9-bit view upward
    wire [2:0]    pw     = (k[p] >= WSEL_PAR_MIN) ? 3'(dw >> 3) : 3'h0;
    assign word[p] = bitpos[AW-1:5];
    assign dlow[p] = ~(32'hFFFF_FFFF << dw);
    assign plow[p] = ~(4'hF << pw);
    assign msk[p]  = {plow[p] << lane, dlow[p] << off};
    assign wd[p]   = {pin[p] << lane, din[p] << off};
    // narrow views slice, wide views concatenate the same stored bits
    assign rd_d[p] = (mem_q[word[p]][DW-1:0] >> off) & dlow[p];
    assign rd_p[p] = (mem_q[word[p]][TW-1:DW] >> lane) & plow[p];

    // output lanes change only on an active edge with the gate asserted
    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
        clkp_r[p] <= 1'b0;
        dout_r[p] <= PRESET_RST;
        pout_r[p] <= 4'h0;
        wcnt_r[p] <= 16'h0000;
      end else begin
        clkp_r[p] <= clk_in[p];
        if (wr[p]) begin
          wcnt_r[p] <= wcnt_r[p] + 16'h0001;
        end
        if (go[p]) begin
          if (pre_act[p]) begin
            dout_r[p] <= preset_r[p] & dlow[p];
            pout_r[p] <= ppar_r[PW*p +: PW] & plow[p];
          end else if (!we_act[p]) begin
            dout_r[p] <= rd_d[p];
            pout_r[p] <= rd_p[p];
          end else begin
            unique case (wmode[p])
              WM_WRITE_FIRST: begin
                dout_r[p] <= din[p] & dlow[p];
                pout_r[p] <= pin[p] & plow[p];
              end
              WM_READ_FIRST: begin
                dout_r[p] <= rd_d[p];
                pout_r[p] <= rd_p[p];
              end
              WM_NO_CHANGE: begin
                dout_r[p] <= dout_r[p];
              end
              default: begin
                dout_r[p] <= dout_r[p];  // unused code behaves as hold
              end
            endcase
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared array
  ////////////////////////////////////////////////////////////////////////////
  // both ports in the same word merge bit masks; overlapping bits are the
  // user's hazard and port b simply wins there
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= MEM_INIT;
      end
    end else if (wr[0] && wr[1] && (word[0] == word[1])) begin
      mem_q[word[0]] <= (mem_q[word[0]] & ~msk[0] & ~msk[1]) | (wd[0] & msk[0] & ~msk[1]) |
                        (wd[1] & msk[1]);
    end else begin
      if (wr[0]) begin
        mem_q[word[0]] <= (mem_q[word[0]] & ~msk[0]) | (wd[0] & msk[0]);
      end
      if (wr[1]) begin
        mem_q[word[1]] <= (mem_q[word[1]] & ~msk[1]) | (wd[1] & msk[1]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence s_read_a;
    go[0] && !we_act[0] && !pre_act[0];
  endsequence
  sequence s_write_a;
    go[0] && we_act[0] && !pre_act[0];
  endsequence
  sequence s_read_b;
    go[1] && !we_act[1] && !pre_act[1];
  endsequence

  property p_store_gated;
    (!wr[0] && !wr[1]) |=> (mem_q[$past(word[0])] == $past(mem_q[word[0]]));
  endproperty
  a_store_gated: assert property (p_store_gated) else $error("array changed without a write");

  property p_store_bits;
    (wr[0] && !wr[1]) |=> ((mem_q[$past(word[0])] & $past(msk[0])) == ($past(wd[0]) & $past(msk[0])));
  endproperty
  a_store_bits: assert property (p_store_bits) else $error("written bits not stored");

  property p_read;
    s_read_a |=> (dout_r[0] == $past(rd_d[0])) && (pout_r[0] == $past(rd_p[0]));
  endproperty
  a_read: assert property (p_read) else $error("read lanes wrong");

  // port b has its own read path into the shared array
  property p_read_b;
    s_read_b |=> (dout_r[1] == $past(rd_d[1])) && (pout_r[1] == $past(rd_p[1]));
  endproperty
  a_read_b: assert property (p_read_b) else $error("port b read lanes wrong");

  // preset wins over read and write, masked to the configured width
  property p_preset;
    (go[0] && pre_act[0]) |=> (dout_r[0] == ($past(preset_r[0]) & $past(dlow[0]))) &&
                              (pout_r[0] == ($past(ppar_r[PW-1:0]) & $past(plow[0])));
  endproperty
  a_preset: assert property (p_preset) else $error("preset lanes wrong");

  property p_write_first;
    s_write_a ##0 (wmode[0] == WM_WRITE_FIRST) |=> (dout_r[0] == ($past(din[0]) & $past(dlow[0])));
  endproperty
  a_write_first: assert property (p_write_first) else $error("write-first output wrong");

  property p_read_first;
    s_write_a ##0 (wmode[0] == WM_READ_FIRST) |=> (dout_r[0] == $past(rd_d[0]));
  endproperty
  a_read_first: assert property (p_read_first) else $error("read-first output wrong");

  property p_no_change;
    s_write_a ##0 (wmode[0] == WM_NO_CHANGE) |=> $stable(dout_r[0]);
  endproperty
  a_no_change: assert property (p_no_change) else $error("no-change output moved");

  property p_idle_hold;
    !go[1] |=> $stable(dout_r[1]) && $stable(pout_r[1]);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("output moved without active edge");

  // port b must leave both the array and its lanes alone in one-port form
  property p_single;
    (single && !wr[0]) |=> (mem_q[$past(word[1])] == $past(mem_q[word[1]])) && $stable(dout_r[1]);
  endproperty
  a_single: assert property (p_single) else $error("port b active in one-port form");

  property p_no_parity;
    (k[0] < WSEL_PAR_MIN) |-> (rd_p[0] == 4'h0) && (msk[0][TW-1:DW] == 4'h0);
  endproperty
  a_no_parity: assert property (p_no_parity) else $error("parity lane used at narrow width");

  property p_mult;
    O_MULT_A_HI == I_PA_DATA_IN_LANES[31:16];
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier share wrong");
endmodule

/* dv/dpbr_user_port.sv */
`timescale 1ns/1ps
// fabric-side user logic that drives one port of the memory
module dpbr_user_port import dpbr_pkg::*; (
  input  wire logic          i_clk,
  output logic               o_port_clk,
  output logic               o_gate,
  output logic               o_write,
  output logic               o_preset,
  output logic [AW-1:0]      o_addr,
  output logic [DW-1:0]      o_data,
  output logic [PW-1:0]      o_par
);
  // idle state: port clock low so the first access shows a clean rise
  initial begin
    o_port_clk = 1'b0;
    o_gate     = 1'b0;
    o_write    = 1'b0;
    o_preset   = 1'b0;
    o_addr     = '0;
    o_data     = '0;
    o_par      = '0;
  end

  //////////////////////////////////////////////////////////////
  // one access: controls first, then a single rising port edge
  // callers run one port at a time, so no two accesses collide
  task automatic op(input logic g, w, ps, input logic [AW-1:0] a,
                    input logic [DW-1:0] d, input logic [PW-1:0] p);
    o_gate   <= g;
    o_write  <= w;
    o_preset <= ps;
    o_addr   <= a;
    o_data   <= d;
    o_par    <= p;
    @(posedge i_clk);
    o_port_clk <= 1'b1;  // controls held steady across the taken edge
    @(posedge i_clk);
    // clock stands still between accesses; address, data and parity lines show inverted values,
    // so a stale copy of the old ones cannot pass by luck
    o_port_clk <= 1'b0;
    o_gate     <= 1'b0;
    o_write    <= 1'b0;
    o_addr     <= ~a;
    o_data     <= ~d;
    o_par      <= ~p;
    @(posedge i_clk);
  endtask
endmodule

/* dv/dpbr_top_tb.sv */
`timescale 1ns/1ps
module dpbr_top_tb;
  import dpbr_pkg::*;
  logic            clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [PAW-1:0]  paddr = '0;
  logic [31:0]     pwdata = '0, prdata;
  logic            pready, pslverr;
  wire             ck_a, g_a, w_a, ps_a, ck_b, g_b, w_b, ps_b;
  wire  [AW-1:0]   ad_a, ad_b;
  wire  [DW-1:0]   di_a, di_b;
  wire  [PW-1:0]   pi_a, pi_b;
  logic [DW-1:0]   do_a, do_b;
  logic [PW-1:0]   po_a, po_b;
  logic [15:0]     ma, mb;
  int              failures = 0, check_count = 0;

  always #20 clk = ~clk;  // 25 MHz core clock

  dpbr_top u_dut (
    .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_PA_CLK(ck_a), .I_PA_GATE(g_a), .I_PA_WRITE(w_a), .I_PA_OUTPUT_PRESET(ps_a), .I_PA_ADDR(ad_a),
    .I_PA_DATA_IN_LANES(di_a), .I_PA_PARITY_IN_LANES(pi_a), .O_PA_DATA_OUT_LANES(do_a),
    .O_PA_PARITY_OUT_LANES(po_a), .O_MULT_A_HI(ma),
    .I_PB_CLK(ck_b), .I_PB_GATE(g_b), .I_PB_WRITE(w_b), .I_PB_OUTPUT_PRESET(ps_b), .I_PB_ADDR(ad_b),
    .I_PB_DATA_IN_LANES(di_b), .I_PB_PARITY_IN_LANES(pi_b), .O_PB_DATA_OUT_LANES(do_b),
    .O_PB_PARITY_OUT_LANES(po_b), .O_MULT_B_HI(mb));
  dpbr_user_port u_pa (.i_clk(clk), .o_port_clk(ck_a), .o_gate(g_a), .o_write(w_a),
    .o_preset(ps_a), .o_addr(ad_a), .o_data(di_a), .o_par(pi_a));
  dpbr_user_port u_pb (.i_clk(clk), .o_port_clk(ck_b), .o_gate(g_b), .o_write(w_b),
    .o_preset(ps_b), .o_addr(ad_b), .o_data(di_b), .o_par(pi_b));

  //////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [35:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [PAW-1:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask

  // control word built from its fields
  function automatic logic [31:0] ctrl(input int wa, wb, ma, sg, ia);
    return 32'(wa) | 32'(wb) << CTRL_W_STEP | 32'(ma) << CTRL_MA_LSB | 32'(sg) << CTRL_SINGLE_BIT
           | 32'(ia) << CTRL_INVA_LSB;
  endfunction

  task automatic cfg(input logic [31:0] v);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ADDR_CTRL, v, r, e);
  endtask

  //////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    apb(1'b0, ADDR_CTRL, '0, r, e);
    chk(36'(r), 36'(CTRL_RST), "ctrl reset value");
    apb(1'b0, 12'h020, '0, r, e);
    chk({3'h0, e, r}, 36'h1_0000_0000, "unmapped read");
    $display("t_regs done");
  endtask

  task automatic t_cross;
    cfg(ctrl(5, 5, 0, 0, 0));
    u_pa.op(1, 1, 0, 14'h0005, 32'hA5A5_1234, 4'h9);
    chk({po_a, do_a}, 36'h9_A5A5_1234, "write-first echo");
    chk(36'(ma), 36'h0_0000_5A5A, "multiplier a bits");
    u_pb.op(1, 0, 0, 14'h0005, '0, '0);
    chk({po_b, do_b}, 36'h9_A5A5_1234, "a to b");
    u_pb.op(1, 1, 0, 14'h0006, 32'h0F1E_2D3C, 4'h6);
    chk(36'(mb), 36'h0_0000_F0E1, "multiplier b bits");
    u_pa.op(1, 0, 0, 14'h0006, '0, '0);
    chk({po_a, do_a}, 36'h6_0F1E_2D3C, "b to a");
    $display("t_cross done");
  endtask

  task automatic t_gate;
    u_pa.op(0, 1, 0, 14'h0005, 32'hDEAD_BEEF, 4'h1);
    u_pa.op(1, 0, 0, 14'h0005, '0, '0);
    chk({po_a, do_a}, 36'h9_A5A5_1234, "gated-off write");
    cfg(ctrl(5, 5, 0, 0, 1 << INV_GATE));  // gate now active low
    u_pa.op(0, 1, 0, 14'h0005, 32'h1357_9BDF, 4'h2);
    cfg(ctrl(5, 5, 0, 0, 0));
    u_pa.op(1, 0, 0, 14'h0005, '0, '0);
    chk({po_a, do_a}, 36'h2_1357_9BDF, "inverted gate");
    $display("t_gate done");
  endtask

  // a read of another word first, so hold and read-first differ
  task automatic t_modes;
    logic [31:0] old7, v8, nw;
    old7 = '0;
    for (int m = 0; m < 4; m++) begin
      cfg(ctrl(5, 5, m, 0, 0));
      v8 = 32'h8888_0000 + m;
      nw = 32'h7777_0000 + m;
      u_pa.op(1, 1, 0, 14'h0008, v8, '0);
      u_pa.op(1, 0, 0, 14'h0008, '0, '0);
      u_pa.op(1, 1, 0, 14'h0007, nw, '0);
      chk(36'(do_a), 36'(m == 0 ? nw : m == 1 ? old7 : v8), "write mode");
      old7 = nw;
    end
    $display("t_modes done");
  endtask

  task automatic t_match;
    int dw;
    cfg(ctrl(3, 5, 0, 0, 0));
    for (int i = 0; i < 4; i++) begin
      u_pa.op(1, 1, 0, 14'(8 + i), 32'(8'h10 + i), 4'(i % 2));
    end
    u_pb.op(1, 0, 0, 14'h0002, '0, '0);
    chk({po_b, do_b}, 36'hA_1312_1110, "narrow to wide");
    u_pb.op(1, 1, 0, 14'h0002, 32'hC3A5_96E1, 4'hB);
    for (int k = 0; k < 6; k++) begin
      dw = 1 << k;
      cfg(ctrl(k, 5, 0, 0, 0));
      u_pa.op(1, 0, 0, 14'((96 >> k) - 1), '0, '0);
      chk(36'(do_a), (36'h0_C3A5_96E1 >> (32 - dw)) & ((36'h1 << dw) - 1), "slice");
      chk(36'(po_a), k < 3 ? 36'h0 : 36'(4'hB >> (4 - dw / 8)), "parity");
    end
    cfg(ctrl(0, 5, 0, 0, 0));
    u_pa.op(1, 1, 0, 14'h3FFF, 32'h0000_0001, '0);
    u_pb.op(1, 0, 0, 14'h01FF, '0, '0);
    chk(36'(do_b), 36'h0_8000_0000, "last bit");
    $display("t_match done");
  endtask

  task automatic t_preset_single;
    logic [31:0] r;
    logic        e;
    apb(1'b1, ADDR_PRESET_A, 32'hFFFF_5A5A, r, e);
    apb(1'b1, ADDR_PRESET_B, 32'h0123_4567, r, e);
    apb(1'b1, ADDR_PRESET_PAR, 32'h0000_00F7, r, e);
    apb(1'b0, ADDR_PRESET_A, '0, r, e);
    chk(36'(r), 36'h0_FFFF_5A5A, "preset readback");
    cfg(ctrl(4, 5, 0, 0, 0));
    u_pa.op(1, 0, 1, 14'h0000, '0, '0);
    chk({po_a, do_a}, 36'h3_0000_5A5A, "preset load");
    u_pb.op(1, 0, 1, 14'h0000, '0, '0);
    chk({po_b, do_b}, 36'hF_0123_4567, "preset load b");
    cfg(ctrl(5, 5, 0, 1, 0));
    u_pb.op(1, 1, 0, 14'h0009, 32'hFACE_0FF1, 4'hF);
    chk({po_b, do_b}, 36'hF_0123_4567, "port b held in one-port mode");
    u_pa.op(1, 0, 0, 14'h0009, '0, '0);
    chk({po_a, do_a}, 36'h0, "one-port mode");
    apb(1'b0, ADDR_STATUS, '0, r, e);
    chk(36'(r), 36'h0_0002_000F, "gated write counts");
    $display("t_preset_single done");
  endtask

  //////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence after a ten-cycle reset
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_cross();
    t_gate();
    t_modes();
    t_match();
    t_preset_single();
    wrap_up();
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
